// File: hw/rtc_event_params.svh
// Summary of operation
// [RQ1] compare alarm date, hours, minutes, seconds with current time; match is alarm
// [RQ2] alarm field msb is match-select: 0 includes field, 1 excludes it
// [RQ3] all four match-selects set gives an alarm every second
// [RQ4] seconds only per minute, plus minutes hourly, plus hours daily, all exact
// [RQ5] alarm match sets the alarm flag in the flags register
// [RQ6] reading flags clears all flags, only after the read completes; the code clears only the bits that the read returned
// [RQ7] watchdog counts down on 32 Hz tick, halted while oscillator stopped
// [RQ8] at power up stored timeout loads the counter and counting starts
// [RQ9] writing the kick bit as 1 reloads the counter and restarts it
// [RQ10] counter reaching 0 sets watchdog flag and, if enabled, the pin
// [RQ11] timeout field D5-D0 writable only while write-lock bit is 0
// [RQ12] timeout value 0 disables the watchdog entirely
// [RQ13] watchdog, alarm and power-fail flags set by their own events
// [RQ14] on backup supply all host reads and writes are refused
// [RQ15] pin driven when any source has both flag and enable high
// [RQ16] enable 0 sets only the flag; enable 1 also drives the pin
// [RQ17] polarity 1 active high push-pull on main only; 0 open-drain low
// [RQ18] pulse-select 1 gives about 200 ms pulse; 0 holds until flags read
// [RQ19] in pulse mode a flags read ends the pulse at once
// [RQ20] in backup only alarm drives pin, and only when active low; an active-low pulse begun on main supply still runs out in backup
// [RQ21] interrupt control resets to 00h; 24h on power-on without battery
// [RQ22] host must not read flags while pin acts as host reset
// [RQ23] flag event in the same cycle as clearing read keeps flag set
`ifndef RTC_EVENT_PARAMS_SVH
`define RTC_EVENT_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_FLAGS 15'h7FF0
`define IDX_ALARM_SEC 15'h7FF2
`define IDX_ALARM_MIN 15'h7FF3
`define IDX_ALARM_HOUR 15'h7FF4
`define IDX_ALARM_DATE 15'h7FF5
`define IDX_INT_CTRL 15'h7FF6
`define IDX_WDOG 15'h7FF7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FLAG_WDOG_BIT 7
`define FLAG_ALARM_BIT 6
`define FLAG_PFAIL_BIT 5
`define WD_KICK_BIT 7
`define WD_LOCK_BIT 6
`define ALARM_MATCH_BIT 7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FLAGS_RESET 3'h0
`define INT_CTRL_RESET 8'h00
`define INT_CTRL_NO_BATT 8'h24
`define ALARM_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLOCK_KHZ 100000
`define INT_PULSE_MS 200

`endif

// File: hw/rtc_event_pkg.sv
package rtc_event_pkg;

   // current time of day, bcd, as the clock counters present it
   typedef struct packed {
      logic [7:0] date;
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } time_of_day_t;

   // interrupt control layout
   typedef struct packed {
      logic watchdog_irq_en;
      logic alarm_irq_en;
      logic powerfail_irq_en;
      logic zero4;
      logic active_high;
      logic pulse_mode;
      logic [1:0] zero10;
   } int_ctrl_t;

   // interrupt pin driver state
   typedef enum logic [1:0] {
      PIN_IDLE = 2'b01,
      PIN_PULSE = 2'b10
   } pin_state_t;

   // asynchronous oscillator side inputs
   typedef struct packed {
      logic osc_running;
      logic tick_32hz;
      logic tick_1hz;
      logic vcc_low;
      logic on_backup;
   } osc_inputs_t;

endpackage

// File: hw/rtc_alarm_watchdog_irq.sv
`timescale 1ns/10ps
`include "rtc_event_params.svh"

module rtc_alarm_watchdog_irq #(
   parameter int PULSE_CYCLES = `INT_PULSE_MS * `CLOCK_KHZ,
   parameter int TIMEOUT_WIDTH = 6
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [16:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // oscillator and power monitor, asynchronous
   input wire rtc_event_pkg::osc_inputs_t osc_in,
   // time of day from the clock counters, stable within a second
   input wire rtc_event_pkg::time_of_day_t now,
   // straps sampled just after reset release
   input wire logic [TIMEOUT_WIDTH-1:0] stored_timeout,
   input wire logic battery_present,
   // interrupt pin
   output logic int_pin_out,
   output logic int_pin_oe,
   // flag status view
   output logic [2:0] flags_out
);
   import rtc_event_pkg::*;

   localparam int SYNC_W = $bits(osc_inputs_t);

   // ----------------------------------------------------------------
   // decoding
   // ----------------------------------------------------------------
   // register index from byte address; misaligned addresses never match
   function automatic logic hit(input logic [16:0] addr, input logic [14:0] idx);
      hit = (addr == {idx, 2'b00});
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic [SYNC_W-1:0] sync3;
   osc_inputs_t osc_q;
   osc_inputs_t osc_prev;

   // three stages; a level is accepted only once stage 2 and 3 agree
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= osc_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // filtered level per input bit
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_filter
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               osc_q[gi] <= 1'b0;
            end else if (sync2[gi] == sync3[gi]) begin
               osc_q[gi] <= sync3[gi];
            end
         end
      end
   endgenerate

   // previous filtered level for edge detection
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         osc_prev <= '0;
      end else begin
         osc_prev <= osc_q;
      end
   end

   logic second_edge;
   logic wd_tick;
   logic pfail_edge;
   logic backup;
   assign second_edge = osc_q.tick_1hz & ~osc_prev.tick_1hz;
   assign wd_tick = osc_q.tick_32hz & ~osc_prev.tick_32hz & osc_q.osc_running; // [RQ7]
   assign pfail_edge = osc_q.vcc_low & ~osc_prev.vcc_low;
   assign backup = osc_q.on_backup;

   // ----------------------------------------------------------------
   // power-up straps
   // ----------------------------------------------------------------
   logic started;

   // one cycle after release the straps are taken over
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         started <= 1'b0;
      end else begin
         started <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // apb handshake
   // ----------------------------------------------------------------
   logic setup;
   logic done;
   logic wr_done;
   logic rd_done;
   logic refused;
   assign setup = psel & ~penable;
   assign done = psel & penable & pready;
   assign wr_done = done & pwrite & ~pslverr;
   assign rd_done = done & ~pwrite & ~pslverr;

   // unmapped address or backup supply both answer with an error
   assign refused = backup | ~(hit(paddr, `IDX_FLAGS) | hit(paddr, `IDX_ALARM_SEC)
      | hit(paddr, `IDX_ALARM_MIN) | hit(paddr, `IDX_ALARM_HOUR)
      | hit(paddr, `IDX_ALARM_DATE) | hit(paddr, `IDX_INT_CTRL)
      | hit(paddr, `IDX_WDOG)); // [RQ14]

   // one wait-free access phase; answer registered during setup
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & refused;
      end
   end

   // ----------------------------------------------------------------
   // alarm registers and comparator
   // ----------------------------------------------------------------
   logic [7:0] alarm_reg [4];
   logic [3:0] field_ok;
   logic [7:0] field_mask [4];
   logic [7:0] now_field [4];
   logic alarm_event;

   assign field_mask[0] = 8'h7F;
   assign field_mask[1] = 8'h7F;
   assign field_mask[2] = 8'h3F;
   assign field_mask[3] = 8'h3F;
   assign now_field[0] = now.seconds;
   assign now_field[1] = now.minutes;
   assign now_field[2] = now.hours;
   assign now_field[3] = now.date;

   // seconds, minutes, hours, date in index order 0..3
   generate
      for (gi = 0; gi < 4; gi++) begin : g_alarm
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               alarm_reg[gi] <= `ALARM_RESET;
            end else if (wr_done && hit(paddr, `IDX_ALARM_SEC + 15'(gi))) begin
               alarm_reg[gi] <= pwdata[7:0];
            end
         end
         // excluded field always agrees; masking applies per field alone
         assign field_ok[gi] = alarm_reg[gi][`ALARM_MATCH_BIT] // [RQ2] [RQ4]
            | ((alarm_reg[gi] & field_mask[gi]) == (now_field[gi] & field_mask[gi]));
      end
   endgenerate

   // checked once per new second, so a match fires once, all-ones every second
   assign alarm_event = second_edge & (&field_ok); // [RQ1] [RQ3]

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   logic [TIMEOUT_WIDTH-1:0] timeout;
   logic [TIMEOUT_WIDTH-1:0] wd_count;
   logic write_lock;
   logic wd_write;
   logic wd_kick;
   logic wd_event;
   assign wd_write = wr_done & hit(paddr, `IDX_WDOG);
   assign wd_kick = wd_write & pwdata[`WD_KICK_BIT];

   // timeout changes only while the lock bit held before this write is 0
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         timeout <= '0;
         write_lock <= 1'b0;
      end else if (!started) begin
         timeout <= stored_timeout; // [RQ8]
      end else if (wd_write) begin
         write_lock <= pwdata[`WD_LOCK_BIT];
         if (!write_lock) begin
            timeout <= pwdata[TIMEOUT_WIDTH-1:0]; // [RQ11]
         end
      end
   end

   // reload on kick or after expiry; zero timeout holds the counter idle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wd_count <= '0;
      end else if (!started) begin
         wd_count <= stored_timeout; // [RQ8]
      end else if (wd_kick) begin
         wd_count <= timeout; // [RQ9]
      end else if (wd_tick && timeout != '0) begin
         if (wd_count <= TIMEOUT_WIDTH'(1)) begin
            wd_count <= timeout;
         end else begin
            wd_count <= wd_count - TIMEOUT_WIDTH'(1); // [RQ7]
         end
      end
   end

   // expiry when the next tick takes the count to zero
   assign wd_event = started & ~wd_kick & wd_tick & (timeout != '0) // [RQ12]
      & (wd_count <= TIMEOUT_WIDTH'(1)); // [RQ10]

   // ----------------------------------------------------------------
   // interrupt control
   // ----------------------------------------------------------------
   int_ctrl_t int_ctrl;

   // without a battery the power-on value enables an active-low pulse
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         int_ctrl <= `INT_CTRL_RESET; // [RQ21]
      end else if (!started) begin
         int_ctrl <= battery_present ? `INT_CTRL_RESET : `INT_CTRL_NO_BATT; // [RQ21]
      end else if (wr_done && hit(paddr, `IDX_INT_CTRL)) begin
         int_ctrl <= pwdata[7:0] & 8'hEC;
      end
   end

   // ----------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------
   logic [2:0] flags;
   logic [2:0] events;
   logic [2:0] next_flags;
   logic flags_read;
   assign events = {wd_event, alarm_event, pfail_edge}; // [RQ13]
   assign flags_read = rd_done & hit(paddr, `IDX_FLAGS);

   // clear only the bits the read returned, then let new events win
   always_comb begin
      next_flags = flags;
      if (flags_read) begin
         next_flags = flags & ~prdata[`FLAG_WDOG_BIT:`FLAG_PFAIL_BIT]; // [RQ6]
      end
      next_flags = next_flags | events; // [RQ5] [RQ23]
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         flags <= `FLAGS_RESET;
         flags_out <= `FLAGS_RESET;
      end else begin
         flags <= next_flags;
         flags_out <= next_flags;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [7:0] read_byte;

   // kick bit reads back as zero; it only acts on write
   always_comb begin
      read_byte = 8'h00;
      if (hit(paddr, `IDX_FLAGS)) begin
         read_byte = {flags, 5'h00};
      end else if (hit(paddr, `IDX_INT_CTRL)) begin
         read_byte = int_ctrl;
      end else if (hit(paddr, `IDX_WDOG)) begin
         read_byte = {1'b0, write_lock, timeout};
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (hit(paddr, `IDX_ALARM_SEC + 15'(i))) begin
               read_byte = alarm_reg[i];
            end
         end
      end
   end

   // data sampled at setup; refused reads return zero
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= (refused | pwrite) ? 32'h0000_0000 : {24'h00_0000, read_byte}; // [RQ14]
      end
   end

   // ----------------------------------------------------------------
   // interrupt pin driver
   // ----------------------------------------------------------------
   logic [2:0] enables;
   logic [2:0] qualified;
   logic [2:0] new_qualified;
   logic pin_active;
   logic [31:0] pulse_count;
   pin_state_t pin_state;

   // in backup only the alarm may start a drive, and only the open-drain form; an open-drain pulse begun on main supply runs on
   always_comb begin
      enables = {int_ctrl.watchdog_irq_en, int_ctrl.alarm_irq_en,
         int_ctrl.powerfail_irq_en}; // [RQ16]
      if (backup) begin
         enables = int_ctrl.active_high ? 3'b000 : {1'b0, int_ctrl.alarm_irq_en, 1'b0}; // [RQ20]
      end
   end
   assign qualified = next_flags & enables; // [RQ15]
   assign new_qualified = events & enables;

   // pulse starts on a fresh qualified event; a flags read cuts it short
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pin_state <= PIN_IDLE;
         pulse_count <= 32'h0000_0000;
      end else begin
         case (pin_state)
            PIN_IDLE: begin
               if (int_ctrl.pulse_mode && (|new_qualified)) begin
                  pin_state <= PIN_PULSE; // [RQ18]
                  pulse_count <= 32'(PULSE_CYCLES - 1);
               end
            end
            PIN_PULSE: begin
               if (flags_read || !int_ctrl.pulse_mode || pulse_count == 32'h0000_0000) begin
                  pin_state <= PIN_IDLE; // [RQ19]
               end else begin
                  pulse_count <= pulse_count - 32'h0000_0001;
               end
            end
            default: begin
               pin_state <= PIN_IDLE;
            end
         endcase
      end
   end

   // level mode follows qualified flags until the clearing read
   always_comb begin
      if (int_ctrl.pulse_mode) begin
         pin_active = (pin_state == PIN_PULSE) & ~flags_read & (pulse_count != 32'h0000_0000);
      end else begin
         pin_active = |qualified; // [RQ18]
      end
   end

   // push-pull high only on main supply; open-drain pulls low when active
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         int_pin_out <= 1'b0;
         int_pin_oe <= 1'b0;
      end else if (int_ctrl.active_high) begin
         int_pin_out <= pin_active & ~backup; // [RQ17]
         int_pin_oe <= ~backup;
      end else begin
         int_pin_out <= 1'b0; // [RQ17]
         int_pin_oe <= pin_active;
      end
   end

endmodule

// File: sim/rtc_event_chk.sv
`timescale 1ns/10ps
`include "rtc_event_params.svh"
module rtc_event_chk #(
   parameter int PULSE_CYCLES = 20,
   parameter int TIMEOUT_WIDTH = 6
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [16:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // events and pin
   input wire rtc_event_pkg::osc_inputs_t osc_in,
   input wire logic int_pin_out,
   input wire logic int_pin_oe,
   input wire logic [2:0] flags_out
);
   import rtc_event_pkg::*;
   localparam logic [16:0] FLAGS_ADDR = {`IDX_FLAGS, 2'b00};
   logic rd_flags;
   logic [2:0] read_bits;
   logic [3:0] since_1hz;
   logic [3:0] since_32hz;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // a flags read that the device accepted
   assign rd_flags = psel && penable && pready && !pwrite && !pslverr && paddr == FLAGS_ADDR;
   // cycles since each tick was high, the 32 Hz one only while the oscillator runs; saturates so a stale tick never looks fresh
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         since_1hz <= 4'hF;
         since_32hz <= 4'hF;
      end else begin
         since_1hz <= osc_in.tick_1hz ? 4'h0 : since_1hz + {3'h0, since_1hz != 4'hF};
         since_32hz <= (osc_in.tick_32hz && osc_in.osc_running) ? 4'h0
            : since_32hz + {3'h0, since_32hz != 4'hF};
      end
   end
   // bits handed out by the last flags read
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         read_bits <= 3'h0;
      end else if (rd_flags) begin
         read_bits <= prdata[7:5];
      end
   end
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   flags_spare_a: assert property (rd_flags |-> prdata[4:0] == 5'h00)
      else $error("flags read shows spare bits");
   read_clears_a: assert property (rd_flags |-> ##2 (flags_out & read_bits) == 3'h0)
      else $error("flags survive a read");
   backup_refused_a: assert property (osc_in.on_backup [*8] ##0 (psel && penable && pready) |-> pslverr)
      else $error("access accepted on backup");
   backup_no_high_a: assert property (osc_in.on_backup [*8] ##0 int_pin_oe |-> !int_pin_out)
      else $error("pin driven high on backup");
   pin_has_cause_a: assert property ($rose(int_pin_out) |-> ##[0:2] flags_out != 3'h0)
      else $error("pin active with no flag");
   alarm_on_tick_a: assert property ($rose(flags_out[1]) |-> since_1hz <= 4'h8)
      else $error("alarm flag without second tick");
   wdog_on_tick_a: assert property ($rose(flags_out[2]) |-> since_32hz <= 4'h8)
      else $error("watchdog flag without running tick");
   read_ends_pin_a: assert property (rd_flags |-> ##[1:3] !int_pin_out)
      else $error("pin held after flags read");
   quiet_after_reset_a: assert property ($fell(reset) |-> !pready && !int_pin_oe)
      else $error("outputs active after reset");
endmodule

bind rtc_alarm_watchdog_irq rtc_event_chk #(
   .PULSE_CYCLES(PULSE_CYCLES),
   .TIMEOUT_WIDTH(TIMEOUT_WIDTH)
) chk (
   .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
   .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .flags_out(flags_out)
);

// File: sim/host_bus_model.sv
`timescale 1ns/10ps
module host_bus_model (
   // clock
   input wire logic clock,
   // apb request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [16:0] paddr,
   output logic [31:0] pwdata,
   // apb answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // bus idle from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 17'h00000;
      pwdata = 32'h00000000;
   end
   // one transfer; the pin serves as an interrupt here, never as a host
   // reset, so a flags read is always allowed
   task automatic xfer(input logic wr, input logic [14:0] idx, input logic [7:0] wd,
      output logic [7:0] rd, output logic err);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~pwdata; // released data carries no stale value
   endtask
endmodule

// File: sim/rtc_alarm_watchdog_irq_tb.sv
`timescale 1ns/10ps
`include "rtc_event_params.svh"
module rtc_alarm_watchdog_irq_tb;
   import rtc_event_pkg::*;
   localparam int PULSE = 20;
   localparam logic [31:0] TARGET = 32'h21081530;
   logic clock = 1'b0;
   logic reset = 1'b1, battery = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, int_pin_out, int_pin_oe, int_wire, err;
   logic [16:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] flags_out;
   logic [7:0] rd;
   osc_inputs_t osc_in = 5'h10;
   time_of_day_t now = 32'h01020304;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   // ----------------------------------------------------------------
   // clock, pin pull-up, parts
   // ----------------------------------------------------------------
   always #5 clock = ~clock;
   assign int_wire = int_pin_oe ? int_pin_out : 1'b1; // open drain needs the pull-up
   rtc_alarm_watchdog_irq #(.PULSE_CYCLES(PULSE), .TIMEOUT_WIDTH(6)) dut (
      .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_in(osc_in), .now(now), .stored_timeout(6'h02), .battery_present(battery),
      .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .flags_out(flags_out));
   host_bus_model host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [14:0] idx, input logic [7:0] d);
      host.xfer(1'b1, idx, d, rd, err);
   endtask
   task automatic rdf(input logic [14:0] idx, input logic [7:0] exp);
      host.xfer(1'b0, idx, 8'h00, rd, err);
      check(rd, exp);
   endtask
   // pin level two edges on, past the registered driver
   task automatic pin(input logic exp);
      repeat (2) @(posedge clock);
      #1;
      check({7'h00, int_wire}, {7'h00, exp});
   endtask
   // square-wave ticks, long enough to clear the input filter
   task automatic tick(input logic sec, input int n);
      repeat (n) begin
         @(posedge clock);
         if (sec) osc_in.tick_1hz <= 1'b1;
         else osc_in.tick_32hz <= 1'b1;
         repeat (8) @(posedge clock);
         osc_in.tick_1hz <= 1'b0;
         osc_in.tick_32hz <= 1'b0;
         repeat (8) @(posedge clock);
      end
   endtask
   task automatic alarm_case(input logic [3:0] incl, input logic [31:0] t,
      input logic [7:0] exp);
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_ALARM_SEC + 15'(i), {~incl[i], TARGET[8*i +: 7]});
      end
      now <= t;
      tick(1'b1, 1);
      rdf(`IDX_FLAGS, exp);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_power_up;
      rdf(`IDX_INT_CTRL, 8'h00);
      host.xfer(1'b0, 15'h7FF1, 8'h00, rd, err);
      check({7'h00, err}, 8'h01);
      tick(1'b0, 2);
      rdf(`IDX_FLAGS, 8'h80);
      rdf(`IDX_FLAGS, 8'h00);
      $display("power up test done");
   endtask
   task automatic test_watchdog;
      wr(`IDX_WDOG, 8'h43);
      wr(`IDX_WDOG, 8'hC1); // locked: timeout stays 3, kick reloads
      rdf(`IDX_WDOG, 8'h43);
      tick(1'b0, 2);
      rdf(`IDX_FLAGS, 8'h00);
      tick(1'b0, 1);
      rdf(`IDX_FLAGS, 8'h80);
      osc_in.osc_running <= 1'b0;
      wr(`IDX_WDOG, 8'hC0);
      tick(1'b0, 4);
      rdf(`IDX_FLAGS, 8'h00);
      osc_in.osc_running <= 1'b1;
      wr(`IDX_WDOG, 8'h00); // first write only drops the lock
      wr(`IDX_WDOG, 8'h00);
      tick(1'b0, 4);
      rdf(`IDX_FLAGS, 8'h00);
      $display("watchdog test done");
   endtask
   task automatic test_alarm;
      alarm_case(4'h0, 32'h01020304, 8'h40);
      alarm_case(4'h1, 32'h01020330, 8'h40);
      alarm_case(4'h1, 32'h21081531, 8'h00);
      alarm_case(4'h3, 32'h01021530, 8'h40);
      alarm_case(4'h7, 32'h21091530, 8'h00);
      alarm_case(4'hF, 32'h22081530, 8'h00);
      alarm_case(4'hF, TARGET, 8'h40);
      $display("alarm test done");
   endtask
   task automatic test_pin;
      for (int i = 0; i < 4; i++) begin
         wr(`IDX_ALARM_SEC + 15'(i), 8'h80);
      end
      wr(`IDX_INT_CTRL, 8'h80);
      tick(1'b1, 1);
      pin(1'b1);
      check({5'h00, flags_out}, 8'h02);
      rdf(`IDX_FLAGS, 8'h40);
      wr(`IDX_INT_CTRL, 8'h40);
      tick(1'b1, 1);
      repeat (PULSE + 10) @(posedge clock);
      pin(1'b0);
      rdf(`IDX_FLAGS, 8'h40);
      pin(1'b1);
      wr(`IDX_INT_CTRL, 8'h48);
      rdf(`IDX_INT_CTRL, 8'h48);
      pin(1'b0);
      check({7'h00, int_pin_oe}, 8'h01);
      tick(1'b1, 1);
      pin(1'b1);
      rdf(`IDX_FLAGS, 8'h40);
      pin(1'b0);
      $display("pin test done");
   endtask
   task automatic test_pulse;
      wr(`IDX_INT_CTRL, 8'h44);
      tick(1'b1, 1);
      pin(1'b0);
      repeat (PULSE) @(posedge clock);
      pin(1'b1);
      check({5'h00, flags_out}, 8'h02);
      rdf(`IDX_FLAGS, 8'h40);
      tick(1'b1, 1);
      rdf(`IDX_FLAGS, 8'h40);
      pin(1'b1);
      $display("pulse test done");
   endtask
   task automatic test_backup;
      wr(`IDX_INT_CTRL, 8'h60);
      osc_in.vcc_low <= 1'b1;
      repeat (10) @(posedge clock);
      pin(1'b0);
      @(posedge clock);
      osc_in.on_backup <= 1'b1;
      repeat (10) @(posedge clock);
      pin(1'b1);
      host.xfer(1'b0, `IDX_FLAGS, 8'h00, rd, err);
      check({7'h00, err}, 8'h01);
      tick(1'b1, 1);
      pin(1'b0);
      @(posedge clock);
      osc_in.on_backup <= 1'b0;
      osc_in.vcc_low <= 1'b0;
      repeat (10) @(posedge clock);
      rdf(`IDX_FLAGS, 8'h60);
      $display("backup test done");
   endtask
   task automatic test_no_battery;
      battery <= 1'b0;
      reset <= 1'b1;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      rdf(`IDX_INT_CTRL, 8'h24);
      $display("no battery test done");
   endtask
   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // hang guard, well above the fewer than one thousand cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict;
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      repeat (2) @(posedge clock);
      test_power_up;
      test_watchdog;
      test_alarm;
      test_pin;
      test_pulse;
      test_backup;
      test_no_battery;
      give_verdict;
   end
endmodule
